// ==== hw/can_status_pkg.sv ====
package can_status_pkg;
    // register offsets, word addressed on the plain port
    localparam logic [3:0] ADDR_COMPARE_LEN = 4'h0;
    localparam logic [3:0] ADDR_CODE_HIT    = 4'h1;
    localparam logic [3:0] ADDR_FIFO_SETUP  = 4'h2;
    localparam logic [3:0] ADDR_FIFO_PTRS   = 4'h3;
    localparam logic [3:0] ADDR_ERR_FLAGS   = 4'h4;
    localparam logic [3:0] ADDR_INT_ENABLE  = 4'h5;
    localparam logic [3:0] ADDR_CTRL        = 4'h6;

    // field positions
    localparam int HIT_LSB        = 8;
    localparam int BUFCNT_LSB     = 13;
    localparam int WPTR_LSB       = 8;
    localparam int ERR_STATE_LSB  = 8;

    // interrupt flag bit positions
    localparam int F_TX_BUF   = 0;
    localparam int F_RX_BUF   = 1;
    localparam int F_RX_OVF   = 2;
    localparam int F_FIFO     = 3;
    localparam int F_ERR      = 5;
    localparam int F_WAKE     = 6;
    localparam int F_INVALID  = 7;
    localparam logic [7:0] FLAG_MASK = 8'hef;

    // reset values and codes
    localparam logic [4:0] COMPARE_LEN_MAX  = 5'h11;
    localparam logic [4:0] FILTER_MAX       = 5'h0f;
    localparam logic [6:0] CODE_NONE        = 7'h40;
    localparam logic [6:0] CODE_ERROR       = 7'h41;
    localparam logic [6:0] CODE_WAKE        = 7'h42;
    localparam logic [6:0] CODE_RX_OVF      = 7'h43;
    localparam logic [6:0] CODE_FIFO        = 7'h44;
    localparam logic [6:0] CODE_INVALID     = 7'h45;
    localparam logic [2:0] BUFCNT_RESET     = 3'h0;
    localparam logic [2:0] BUFCNT_MAX_CODE  = 3'h5;
    localparam logic [5:0] PTR_MAX          = 6'h1f;
    localparam logic [5:0] PTR_RESET        = 6'h00;
    localparam logic [3:0] TX_BUF_LAST      = 4'h7;
    localparam logic [3:0] RX_BUF_LAST      = 4'hf;
endpackage : can_status_pkg

// ==== hw/ptr_bus_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface ptr_bus_if;
    logic [4:0] start_buf;
    logic [5:0] last_buf;
    logic       advance;
    logic [5:0] ptr;
    modport owner (input start_buf, input last_buf, input advance, output ptr);
    modport user  (output start_buf, output last_buf, output advance, input ptr);
endinterface : ptr_bus_if
`default_nettype wire

// ==== hw/fifo_ptr.sv ====
`timescale 1ns/1ns
`default_nettype none
module fifo_ptr (
    input  wire logic   mclk_i,
    input  wire logic   reset_n_i,
    ptr_bus_if.owner    pb
);
    typedef struct packed {
        logic [5:0] ptr;
    } ptr_state_t;

    ptr_state_t st_r;
    ptr_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (pb.advance) begin
            // wrap back to the fifo start buffer
            if (st_r.ptr >= pb.last_buf || st_r.ptr < {1'b0, pb.start_buf}) begin // RULE18
                st_nxt.ptr = {1'b0, pb.start_buf}; // RULE18
            end else begin
                st_nxt.ptr = st_r.ptr + 6'h01;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            st_r.ptr <= can_status_pkg::PTR_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pb.ptr = st_r.ptr;

    a_ptr_in_range: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE7
        st_r.ptr <= can_status_pkg::PTR_MAX)
        else $error("fifo pointer beyond buffer 31");
endmodule : fifo_ptr
`default_nettype wire

// ==== hw/can_status_regs.sv ====
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// RULE1 - compare length is a 5-bit read-only field, zero at reset, codes above 10001 invalid
// RULE2 - largest legal compare length 10001 reaches data byte 3 bit 6
// RULE3 - matched filter number shown as 5-bit read-only field, 0 to 15
// RULE4 - 7-bit interrupt source code, buffers at 0 to 15, 1000000 means none
// RULE5 - codes above 1000000 name non-buffer sources, highest pending enabled shown
// RULE6 - writable 3-bit buffer count, 000 to 101, resets to 000
// RULE7 - read-only 6-bit fifo write pointer, buffers 0 to 31
// RULE8 - read-only 6-bit fifo next-read pointer, same numbering
// RULE9 - read-only flag set while transmitter is bus-off
// RULE10 - read-only flag set while transmitter is error-passive
// RULE11 - read-only flag set while receiver is error-passive
// RULE12 - separate read-only warning flags for transmitter and receiver
// RULE13 - combined warning flag set when either side warns
// RULE14 - error interrupt flag set when any error-state condition arises
// RULE15 - interrupt flags for six event sources, zero at reset; the code keeps seven flags, the error flag included
// RULE16 - writing zero clears a flag, writing one leaves it
// RULE17 - a flag reaches the interrupt output only when enabled
// RULE18 - fifo start field begins fifo area, pointers wrap back to it
module can_status_regs (
    input  wire logic        mclk_i,
    input  wire logic        reset_n_i,
    input  wire logic [3:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [15:0] rdata_o,
    input  wire logic [4:0]  compare_len_i,
    input  wire logic        msg_received_i,
    input  wire logic [4:0]  hit_filter_i,
    input  wire logic        tx_buf_done_i,
    input  wire logic [3:0]  tx_buf_num_i,
    input  wire logic        rx_buf_done_i,
    input  wire logic        rx_overflow_i,
    input  wire logic        fifo_almost_full_i,
    input  wire logic        wakeup_i,
    input  wire logic        invalid_msg_i,
    input  wire logic        fifo_write_i,
    input  wire logic        fifo_read_i,
    input  wire logic        tx_bus_off_i,
    input  wire logic        tx_passive_i,
    input  wire logic        rx_passive_i,
    input  wire logic        tx_warning_i,
    input  wire logic        rx_warning_i,
    output logic             irq_o,
    output logic [6:0]       interrupt_source_code_o,
    output logic [2:0]       dma_buffer_count_o
);
    typedef struct packed {
        logic [15:0] rdata;
        logic [4:0]  data_compare_length;
        logic [4:0]  matched_filter_number;
        logic [6:0]  interrupt_source_code;
        logic [2:0]  dma_buffer_count;
        logic [4:0]  fifo_start_buffer;
        logic [5:0]  err_state;
        logic [5:0]  err_state_prev;
        logic [7:0]  flags;
        logic [7:0]  enables;
        logic [15:0] rx_pending;
        logic [3:0]  last_tx_buf;
        logic        irq;
    } regs_state_t;

    regs_state_t st_r;
    regs_state_t st_nxt;

    ptr_bus_if wr_bus ();
    ptr_bus_if rd_bus ();

    logic [5:0] last_buf;
    logic [5:0] err_now;
    logic [7:0] events;
    logic [7:0] pending;

    localparam int F_TX_BUF_I = can_status_pkg::F_TX_BUF;
    localparam int F_RX_BUF_I = can_status_pkg::F_RX_BUF;
    localparam int F_RX_OVF_I = can_status_pkg::F_RX_OVF;
    localparam int F_FIFO_I   = can_status_pkg::F_FIFO;
    localparam int F_ERR_I    = can_status_pkg::F_ERR;
    localparam int F_WAKE_I   = can_status_pkg::F_WAKE;
    localparam int F_INV_I    = can_status_pkg::F_INVALID;

    // last buffer number of the configured dma area
    always_comb begin
        case (st_r.dma_buffer_count)
            3'h0:    last_buf = 6'h03;
            3'h1:    last_buf = 6'h05;
            3'h2:    last_buf = 6'h07;
            3'h3:    last_buf = 6'h0b;
            3'h4:    last_buf = 6'h0f;
            3'h5:    last_buf = 6'h17;
            default: last_buf = 6'h17;
        endcase
    end

    assign wr_bus.start_buf = st_r.fifo_start_buffer; // RULE18
    assign wr_bus.last_buf  = last_buf;
    assign wr_bus.advance   = fifo_write_i;
    assign rd_bus.start_buf = st_r.fifo_start_buffer; // RULE18
    assign rd_bus.last_buf  = last_buf;
    assign rd_bus.advance   = fifo_read_i;

    fifo_ptr u_write_ptr (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .pb        (wr_bus.owner)
    );

    fifo_ptr u_read_ptr (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .pb        (rd_bus.owner)
    );

    // state bits: 13 bus-off, 12 tx passive, 11 rx passive, 10/9 warnings, 8 any
    assign err_now = {tx_bus_off_i, tx_passive_i, rx_passive_i,        // RULE9 RULE10 RULE11
                      tx_warning_i, rx_warning_i,                       // RULE12
                      tx_warning_i | rx_warning_i};                     // RULE13

    always_comb begin
        events             = 8'h00;
        events[F_TX_BUF_I] = tx_buf_done_i;                             // RULE15
        events[F_RX_BUF_I] = rx_buf_done_i;
        events[F_RX_OVF_I] = rx_overflow_i;
        events[F_FIFO_I]   = fifo_almost_full_i;
        events[F_WAKE_I]   = wakeup_i;
        events[F_INV_I]    = invalid_msg_i;
        // a new error state condition raises the error event
        events[F_ERR_I]    = |(err_now & ~st_r.err_state_prev);        // RULE14
    end

    assign pending = st_r.flags & st_r.enables;                         // RULE17

    always_comb begin
        logic [7:0]  wr_flags;
        logic [15:0] rx_pend;
        logic [6:0]  code;
        wr_flags = st_r.flags;
        rx_pend  = st_r.rx_pending;
        code     = can_status_pkg::CODE_NONE;
        st_nxt   = st_r;
        st_nxt.err_state      = err_now;
        st_nxt.err_state_prev = err_now;
        st_nxt.data_compare_length = (compare_len_i > can_status_pkg::COMPARE_LEN_MAX)
                                     ? st_r.data_compare_length : compare_len_i; // RULE1 RULE2
        if (msg_received_i && hit_filter_i <= can_status_pkg::FILTER_MAX) begin
            st_nxt.matched_filter_number = hit_filter_i;               // RULE3
        end
        if (tx_buf_done_i) begin
            st_nxt.last_tx_buf = tx_buf_num_i;
        end
        // software writes
        if (wr_i) begin
            case (addr_i)
                can_status_pkg::ADDR_FIFO_SETUP: begin
                    if (wdata_i[15:13] <= can_status_pkg::BUFCNT_MAX_CODE) begin
                        st_nxt.dma_buffer_count = wdata_i[15:13];      // RULE6
                    end
                    st_nxt.fifo_start_buffer = wdata_i[4:0];           // RULE18
                end
                can_status_pkg::ADDR_ERR_FLAGS: begin
                    wr_flags = st_r.flags & wdata_i[7:0];              // RULE16
                    if (!wdata_i[F_RX_BUF_I]) begin
                        rx_pend = 16'h0000;
                    end
                end
                can_status_pkg::ADDR_INT_ENABLE: begin
                    st_nxt.enables = wdata_i[7:0] & can_status_pkg::FLAG_MASK;
                end
                default: begin
                end
            endcase
        end
        // set wins over a clear in the same cycle
        st_nxt.flags = (wr_flags | events) & can_status_pkg::FLAG_MASK; // RULE15 RULE16
        if (rx_buf_done_i) begin
            rx_pend[rd_bus.ptr[3:0]] = 1'b1;
        end
        st_nxt.rx_pending = rx_pend;
        // priority: non-buffer sources first, then the last tx buffer, then lowest pending rx buffer
        if (pending[F_ERR_I]) begin
            code = can_status_pkg::CODE_ERROR;                          // RULE5
        end else if (pending[F_WAKE_I]) begin
            code = can_status_pkg::CODE_WAKE;
        end else if (pending[F_RX_OVF_I]) begin
            code = can_status_pkg::CODE_RX_OVF;
        end else if (pending[F_FIFO_I]) begin
            code = can_status_pkg::CODE_FIFO;
        end else if (pending[F_INV_I]) begin
            code = can_status_pkg::CODE_INVALID;
        end else if (pending[F_TX_BUF_I]) begin
            code = {3'h0, st_r.last_tx_buf};                            // RULE4
        end else if (pending[F_RX_BUF_I]) begin
            code = {3'h0, can_status_pkg::RX_BUF_LAST};
            for (int i = 15; i >= 0; i--) begin
                if (st_r.rx_pending[i]) begin
                    code = {3'h0, 4'(i)};                               // RULE4
                end
            end
        end
        st_nxt.interrupt_source_code = code;                            // RULE5
        st_nxt.irq = |pending;                                          // RULE17
        // read data one cycle later
        st_nxt.rdata = 16'h0000;
        if (rd_i) begin
            case (addr_i)
                can_status_pkg::ADDR_COMPARE_LEN:
                    st_nxt.rdata = {11'h000, st_r.data_compare_length};
                can_status_pkg::ADDR_CODE_HIT:
                    st_nxt.rdata = {3'h0, st_r.matched_filter_number, 1'b0,
                                    st_r.interrupt_source_code};
                can_status_pkg::ADDR_FIFO_SETUP:
                    st_nxt.rdata = {st_r.dma_buffer_count, 8'h00, st_r.fifo_start_buffer};
                can_status_pkg::ADDR_FIFO_PTRS:
                    st_nxt.rdata = {2'h0, wr_bus.ptr, 2'h0, rd_bus.ptr}; // RULE7 RULE8
                can_status_pkg::ADDR_ERR_FLAGS:
                    st_nxt.rdata = {2'h0, st_r.err_state, st_r.flags};
                can_status_pkg::ADDR_INT_ENABLE:
                    st_nxt.rdata = {8'h00, st_r.enables};
                default:
                    st_nxt.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            st_r.rdata                 <= 16'h0000;
            st_r.data_compare_length   <= 5'h00;                        // RULE1
            st_r.matched_filter_number <= 5'h00;
            st_r.interrupt_source_code <= can_status_pkg::CODE_NONE;    // RULE4
            st_r.dma_buffer_count      <= can_status_pkg::BUFCNT_RESET; // RULE6
            st_r.fifo_start_buffer     <= 5'h00;
            st_r.err_state             <= 6'h00;
            st_r.err_state_prev        <= 6'h00;
            st_r.flags                 <= 8'h00;                        // RULE15
            st_r.enables               <= 8'h00;
            st_r.rx_pending            <= 16'h0000;
            st_r.last_tx_buf           <= 4'h0;
            st_r.irq                   <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata_o                 = st_r.rdata;
    assign irq_o                   = st_r.irq;
    assign interrupt_source_code_o = st_r.interrupt_source_code;
    assign dma_buffer_count_o      = st_r.dma_buffer_count;

    // a flag that is disabled never shows on the interrupt line
    a_irq_gated: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE17
        irq_o |-> $past(pending) != 8'h00)
        else $error("interrupt without enabled flag");

    a_flag_sticky: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE16
        (st_r.flags[F_WAKE_I] && !(wr_i && addr_i == can_status_pkg::ADDR_ERR_FLAGS))
        |=> st_r.flags[F_WAKE_I])
        else $error("flag lost without clearing write");

    a_flag_set: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE15
        invalid_msg_i |=> st_r.flags[F_INV_I])
        else $error("event did not set its flag");

    a_code_none: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE4
        (st_r.enables == 8'h00) |=> interrupt_source_code_o == can_status_pkg::CODE_NONE)
        else $error("code not idle with no enables");

    a_err_code: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE5
        pending[F_ERR_I] |=> interrupt_source_code_o == can_status_pkg::CODE_ERROR)
        else $error("error source not given priority");

    a_bufcnt_legal: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE6
        dma_buffer_count_o <= can_status_pkg::BUFCNT_MAX_CODE)
        else $error("illegal buffer count");

    a_warn_any: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE13
        (tx_warning_i || rx_warning_i) |=> st_r.err_state[0])
        else $error("combined warning missing");

    a_busoff_err: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE14
        $rose(tx_bus_off_i) |=> st_r.flags[F_ERR_I])
        else $error("error flag not raised on bus off");

    a_len_legal: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE2
        st_r.data_compare_length <= can_status_pkg::COMPARE_LEN_MAX)
        else $error("compare length beyond legal code");

    a_len_follow: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE1
        compare_len_i <= can_status_pkg::COMPARE_LEN_MAX |=>
        st_r.data_compare_length == $past(compare_len_i))
        else $error("legal compare length not taken");

    a_hit_capture: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE3
        msg_received_i && hit_filter_i <= can_status_pkg::FILTER_MAX |=>
        st_r.matched_filter_number == $past(hit_filter_i))
        else $error("filter number not captured");

    a_code_gap: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE4
        !(interrupt_source_code_o inside {[7'h10:7'h3f]}))
        else $error("reserved interrupt code shown");

    a_busoff_shown: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE9
        tx_bus_off_i |=> st_r.err_state[5])
        else $error("bus-off state not shown");

    a_txpass_shown: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE10
        tx_passive_i |=> st_r.err_state[4])
        else $error("tx passive state not shown");

    a_rxpass_shown: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE11
        rx_passive_i |=> st_r.err_state[3])
        else $error("rx passive state not shown");

    a_warn_split: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE12
        (tx_warning_i != rx_warning_i) |=> (st_r.err_state[2] != st_r.err_state[1]))
        else $error("warning flags not separate");

    a_warn_clear: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE13
        !(tx_warning_i || rx_warning_i) |=> !st_r.err_state[0])
        else $error("combined warning stuck");

    a_fifo_flag: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE15
        fifo_almost_full_i |=> st_r.flags[F_FIFO_I])
        else $error("almost full flag not set");

    a_irq_follows: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE17
        (pending != 8'h00) |=> irq_o)
        else $error("enabled flag without interrupt");

    sequence s_inv_clear;
        wr_i && addr_i == can_status_pkg::ADDR_ERR_FLAGS && !wdata_i[F_INV_I] && !invalid_msg_i;
    endsequence

    a_zero_clears: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE16
        s_inv_clear |=> !st_r.flags[F_INV_I])
        else $error("zero write left flag set");

    sequence s_count_write;
        wr_i && addr_i == can_status_pkg::ADDR_FIFO_SETUP
        && wdata_i[15:13] <= can_status_pkg::BUFCNT_MAX_CODE;
    endsequence

    sequence s_setup_read;
        !wr_i ##1 rd_i && addr_i == can_status_pkg::ADDR_FIFO_SETUP;
    endsequence

    // write, idle cycle, read: the read returns the count written
    a_count_read: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // RULE6
        s_count_write ##1 s_setup_read |=>
        (rdata_o & 16'he000) == ($past(wdata_i, 3) & 16'he000))
        else $error("buffer count read back wrong");
endmodule : can_status_regs
`default_nettype wire

// ==== sim/can_node_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// bus-side event source: buffer events, fifo moves, filter hits, error states
// ev_o: 0 tx done, 1 rx done, 2 overflow, 3 almost full, 4 fifo write,
// 5 fifo read, 6 wake-up, 7 invalid, 8 message matched
module can_node_model (
    input  wire logic       mclk_i,
    output logic      [8:0] ev_o,
    output logic      [4:0] val_o,
    output logic      [4:0] state_o
);
    initial begin
        ev_o    = 9'h000;
        val_o   = 5'h00;
        state_o = 5'h00;
    end

    // one-cycle pulse; the number is scrambled once the pulse is over
    task automatic fire(input logic [8:0] ev, input logic [4:0] v);
        @(posedge mclk_i);
        ev_o  <= ev;
        val_o <= v;
        @(posedge mclk_i);
        ev_o  <= 9'h000;
        val_o <= ~v;
    endtask : fire

    // levels: 0 rx warning, 1 tx warning, 2 rx passive, 3 tx passive, 4 bus-off
    task automatic set_state(input logic [4:0] s);
        @(posedge mclk_i);
        state_o <= s;
    endtask : set_state
endmodule : can_node_model
`default_nettype wire

// ==== sim/can_status_interrupt_fifo_test.sv ====
`timescale 1ns/1ns
`default_nettype none
module can_status_interrupt_fifo_test;
    logic        mclk_i        = 1'b0;
    logic        reset_n_i     = 1'b0;
    logic [3:0]  addr_i        = 4'h0;
    logic [15:0] wdata_i       = 16'h0000;
    logic        wr_i          = 1'b0;
    logic        rd_i          = 1'b0;
    logic [4:0]  compare_len_i = 5'h00;
    wire  logic [15:0] rdata_o;
    wire  logic        irq_o;
    wire  logic [6:0]  code_o;
    wire  logic [2:0]  count_o;
    wire  logic [8:0]  ev;
    wire  logic [4:0]  val;
    wire  logic [4:0]  st;
    int          failures    = 0;
    int          check_count = 0;
    int          i;
    int          k;
    logic [15:0] d;
    logic [15:0] fl;
    logic [5:0]  w;
    logic [5:0]  r;
    int          pos [6] = '{1, 0, 7, 3, 2, 6};
    // rx event lands in the next-read buffer, which is 2 by then
    logic [6:0]  cd  [6] = '{7'h02, 7'h05, 7'h45, 7'h44, 7'h43, 7'h42};

    always #5 mclk_i = ~mclk_i;

    can_node_model node (.mclk_i(mclk_i), .ev_o(ev), .val_o(val), .state_o(st));

    can_status_regs DUT (
        .mclk_i(mclk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .compare_len_i(compare_len_i),
        .msg_received_i(ev[8]), .hit_filter_i(val), .tx_buf_done_i(ev[0]),
        .tx_buf_num_i(val[3:0]), .rx_buf_done_i(ev[1]), .rx_overflow_i(ev[2]),
        .fifo_almost_full_i(ev[3]), .wakeup_i(ev[6]), .invalid_msg_i(ev[7]),
        .fifo_write_i(ev[4]), .fifo_read_i(ev[5]), .tx_bus_off_i(st[4]),
        .tx_passive_i(st[3]), .rx_passive_i(st[2]), .tx_warning_i(st[1]),
        .rx_warning_i(st[0]), .irq_o(irq_o), .interrupt_source_code_o(code_o),
        .dma_buffer_count_o(count_o)
    );

    task automatic reg_wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge mclk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= v;
        @(posedge mclk_i);
        wr_i    <= 1'b0;
    endtask : reg_wr

    // data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge mclk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i   <= 1'b0;
        #1 v = rdata_o;
    endtask : reg_rd

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t word %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_code(input logic [6:0] got, input logic [6:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t code %h expected %h", $time, got, exp);
        end
    endtask : chk_code

    task automatic chk_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t irq %b expected %b", $time, got, exp);
        end
    endtask : chk_bit

    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
        logic [15:0] v;
        reg_rd(a, v);
        chk_word(v, exp);
    endtask : rd_chk

    task automatic print_verdict();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    // every wait below is a fixed count, so one ceiling covers a hang
    initial begin
        repeat (20000) @(posedge mclk_i);
        failures++;
        print_verdict();
    end

    initial begin
        repeat (3) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        rd_chk(can_status_pkg::ADDR_COMPARE_LEN, 16'h0000);
        rd_chk(can_status_pkg::ADDR_CODE_HIT, 16'h0040);
        rd_chk(can_status_pkg::ADDR_FIFO_SETUP, 16'h0000);
        rd_chk(can_status_pkg::ADDR_FIFO_PTRS, 16'h0000);
        rd_chk(can_status_pkg::ADDR_ERR_FLAGS, 16'h0000);
        rd_chk(can_status_pkg::ADDR_INT_ENABLE, 16'h0000);
        rd_chk(can_status_pkg::ADDR_CTRL, 16'h0000);
        chk_code(code_o, 7'h40);
        chk_bit(irq_o, 1'b0);
        $display("test reset done");
        // an invalid length must not replace the held one
        @(posedge mclk_i) compare_len_i <= 5'h11;
        rd_chk(can_status_pkg::ADDR_COMPARE_LEN, 16'h0011);
        @(posedge mclk_i) compare_len_i <= 5'h12;
        rd_chk(can_status_pkg::ADDR_COMPARE_LEN, 16'h0011);
        @(posedge mclk_i) compare_len_i <= 5'h05;
        rd_chk(can_status_pkg::ADDR_COMPARE_LEN, 16'h0005);
        reg_wr(can_status_pkg::ADDR_COMPARE_LEN, 16'h001f);
        rd_chk(can_status_pkg::ADDR_COMPARE_LEN, 16'h0005);
        $display("test compare length done");
        node.fire(9'h100, 5'h0f);
        rd_chk(can_status_pkg::ADDR_CODE_HIT, 16'h0f40);
        node.fire(9'h100, 5'h14);
        rd_chk(can_status_pkg::ADDR_CODE_HIT, 16'h0f40);
        $display("test filter hit done");
        for (i = 0; i < 6; i++) begin
            reg_wr(can_status_pkg::ADDR_FIFO_SETUP, {i[2:0], 13'h0000});
            rd_chk(can_status_pkg::ADDR_FIFO_SETUP, {i[2:0], 13'h0000});
            chk_code({4'h0, count_o}, {4'h0, i[2:0]});
        end
        reg_wr(can_status_pkg::ADDR_FIFO_SETUP, 16'hc000);
        reg_rd(can_status_pkg::ADDR_FIFO_SETUP, d);
        chk_word({d[15:13], 13'h0000}, 16'ha000);
        $display("test buffer count done");
        // count code 0 with start 1: last buffer is 3, so wrap goes 3 to 1
        reg_wr(can_status_pkg::ADDR_FIFO_SETUP, 16'h0001);
        // pointers stay at zero until their first move jumps them to the start
        w = 6'h00;
        r = 6'h00;
        rd_chk(can_status_pkg::ADDR_FIFO_PTRS, 16'h0000);
        for (k = 0; k < 6; k++) begin
            node.fire((k < 4) ? 9'h010 : 9'h020, 5'h00);
            if (k < 4) w = (w >= 6'h03 || w < 6'h01) ? 6'h01 : w + 6'h01;
            else r = (r >= 6'h03 || r < 6'h01) ? 6'h01 : r + 6'h01;
            rd_chk(can_status_pkg::ADDR_FIFO_PTRS, {2'b00, w, 2'b00, r});
        end
        $display("test fifo pointers done");
        for (i = 0; i < 5; i++) begin
            node.set_state(5'h00);
            reg_wr(can_status_pkg::ADDR_ERR_FLAGS, 16'h0000);
            node.set_state(5'h01 << i);
            d = (16'h0200 << i) | 16'h0020 | ((i < 2) ? 16'h0100 : 16'h0000);
            rd_chk(can_status_pkg::ADDR_ERR_FLAGS, d);
        end
        chk_bit(irq_o, 1'b0);
        chk_code(code_o, 7'h40);
        reg_wr(can_status_pkg::ADDR_INT_ENABLE, 16'h0020);
        rd_chk(can_status_pkg::ADDR_INT_ENABLE, 16'h0020);
        chk_bit(irq_o, 1'b1);
        chk_code(code_o, 7'h41);
        node.set_state(5'h00);
        reg_wr(can_status_pkg::ADDR_ERR_FLAGS, 16'h0000);
        rd_chk(can_status_pkg::ADDR_ERR_FLAGS, 16'h0000);
        $display("test error states done");
        // sources added from lowest to highest priority, then removed again
        reg_wr(can_status_pkg::ADDR_INT_ENABLE, 16'h00ef);
        fl = 16'h0000;
        for (k = 0; k < 6; k++) begin
            node.fire(9'h001 << pos[k], 5'h05);
            fl = fl | (16'h0001 << pos[k]);
            rd_chk(can_status_pkg::ADDR_ERR_FLAGS, fl);
            chk_code(code_o, cd[k]);
            chk_bit(irq_o, 1'b1);
        end
        reg_wr(can_status_pkg::ADDR_ERR_FLAGS, 16'hffff);
        rd_chk(can_status_pkg::ADDR_ERR_FLAGS, fl);
        for (k = 5; k >= 0; k--) begin
            fl = fl & ~(16'h0001 << pos[k]);
            reg_wr(can_status_pkg::ADDR_ERR_FLAGS, ~(16'h0001 << pos[k]));
            rd_chk(can_status_pkg::ADDR_ERR_FLAGS, fl);
            chk_code(code_o, (k > 0) ? cd[k - 1] : 7'h40);
        end
        chk_bit(irq_o, 1'b0);
        $display("test interrupt flags done");
        print_verdict();
    end
endmodule : can_status_interrupt_fifo_test
`default_nettype wire
